// ==== common/can_tx_pkg.sv ====
// constants, codes and carriers for the transmit scheduler and interrupt coder
// assumes one clock domain and an apb register port of 8 address bits
package can_tx_pkg;
  // ***************
  // sizes
  // ***************
  localparam int NBUF = 15;
  localparam int DIAG_W = 8;
  // ***************
  // register offsets
  // ***************
  localparam logic [7:0] OFF_IRQ_EN = 8'h00;
  localparam logic [7:0] OFF_IRQ_PEND = 8'h04;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h08;
  localparam logic [7:0] OFF_CODE_EN = 8'h0c;
  localparam logic [7:0] OFF_STAT_PEND = 8'h10;
  localparam logic [7:0] OFF_ERR_DIAG = 8'h14;
  localparam logic [7:0] OFF_BUF_SEL = 8'h18;
  localparam logic [7:0] OFF_BUF_STAT = 8'h1c;
  // ***************
  // field positions and reset values
  // ***************
  localparam int ERR_BIT = 15;
  localparam int PRI_LSB = 4;
  localparam int RTR_BIT = 8;
  localparam int IRQ_FLAG_BIT = 4;
  localparam logic [15:0] IRQ_EN_RST = 16'h0000;
  localparam logic [15:0] CODE_EN_RST = 16'hffff;
  // ***************
  // buffer state codes, bit 0 is the busy bit
  // ***************
  localparam logic [3:0] RX_NOT_ACTIVE = 4'h0;
  localparam logic [3:0] RX_READY = 4'h2;
  localparam logic [3:0] RX_FULL = 4'h4;
  localparam logic [3:0] RX_OVERRUN = 4'h6;
  localparam logic [3:0] TX_NOT_ACTIVE = 4'h8;
  localparam logic [3:0] WAIT_FOR_REMOTE = 4'ha;
  localparam logic [3:0] SEND_ONCE = 4'hc;
  localparam logic [3:0] SEND_ONCE_THEN_ANSWER = 4'he;
  // ***************
  // carriers
  // ***************
  typedef struct packed {
    logic valid;
    logic [3:0] idx;
  } pick_t;
  typedef struct packed {
    logic start;
    logic done;
    logic fail;
  } tx_evt_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SCHED = 3'b010,
    TX_FLIGHT = 3'b100
  } tx_state_t;
endpackage : can_tx_pkg

// ==== verilog/can_tx_priority_and_irq_code.sv ====
// transmit priority scheduler, transmit buffer states and interrupt coder
// assumes a protocol engine that reports frame start, success and failure
// as one-cycle pulses, and software on apb with zero wait states
// Functional notes
// RL1 - after a frame, rearbitrate at once when another buffer is queued
// RL2 - combined priority is priority field high nibble, buffer index low nibble
// RL3 - the smallest combined priority among scheduled buffers goes next
// RL4 - equal combined priority favours the lower buffer index
// RL5 - software sets inactive-transmit before changing a buffer, waits if busy
// RL6 - software loads identifier and data before writing the trigger code
// RL7 - remote frame: software sets the rtr bit, data loading optional
// RL8 - send-once codes raise a transmit request, wait-for-remote does not
// RL9 - wait-for-remote buffer hit by remote frame transmits automatically
// RL10 - send-once buffer turns busy as soon as it is scheduled
// RL11 - send-once success gives inactive-transmit, or receive-ready for remote
// RL12 - send-once-then-answer reads 1111b while being transmitted
// RL13 - answer mode cycles wait-for-remote, send, wait-for-remote again
// RL14 - writing 1010b only waits for a remote frame
// RL15 - one shared interrupt output; data receive also drives the wake-up unit
// RL16 - buffer interrupt on the four listed state changes
// RL17 - bus error sets error pending flag and diagnostic bits
// RL18 - individual enables; pending read-only, cleared through clear register
// RL19 - enabled highest pending request is coded into the status code field
// RL20 - none 0/0, error 1/0, buffer n 1/n+1, error highest
// RL21 - busy buffer accepts only state code bits 3 to 1
// RL22 - failed or lost frame stays busy and is retried
// RL23 - buffers 10 to 14 give codes 11 to 15
// RL24 - only requested, not busy buffers compete; reevaluated on each change
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module can_tx_priority_and_irq_code
  import can_tx_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // protocol engine side
  input wire tx_evt_t tx_evt,
  input wire logic [NBUF-1:0] rx_remote_hit,
  input wire logic [NBUF-1:0] rx_data_hit,
  input wire logic bus_error,
  input wire logic [DIAG_W-1:0] error_bits,
  output logic tx_req,
  output logic [3:0] tx_index,
  output logic tx_remote,
  // interrupt and wake-up
  output logic can_irq,
  output logic rx_wake
);
  // ***************
  // helpers
  // ***************
  function automatic logic sendable(input logic [3:0] c);
    sendable = (c[3:1] == SEND_ONCE[3:1]) || (c[3:1] == SEND_ONCE_THEN_ANSWER[3:1]);
  endfunction : sendable

  function automatic logic [7:0] comb_pri(input logic [3:0] p, input logic [3:0] i);
    comb_pri = {p, i}; // RL2
  endfunction : comb_pri

  // code after a successful frame, busy bit dropped
  function automatic logic [3:0] done_code(input logic [3:0] c, input logic rtr);
    if (c[3:1] == SEND_ONCE[3:1]) begin
      done_code = rtr ? RX_READY : TX_NOT_ACTIVE; // RL11
    end else if (c[3:1] == SEND_ONCE_THEN_ANSWER[3:1]) begin
      done_code = WAIT_FOR_REMOTE; // RL13
    end else begin
      done_code = {c[3:1], 1'b0};
    end
  endfunction : done_code

  // error first, then buffer 0 upward
  function automatic logic [4:0] irq_code(input logic [15:0] req);
    irq_code = 5'h00;
    for (int i = NBUF - 1; i >= 0; i--) begin
      if (req[i]) begin
        irq_code = {1'b1, 4'(i + 1)}; // RL20 RL23
      end
    end
    if (req[ERR_BIT]) begin
      irq_code = 5'h10; // RL20
    end
  endfunction : irq_code

  // ***************
  // state
  // ***************
  logic [3:0] code_reg [NBUF];
  logic [3:0] pri_reg [NBUF];
  logic [NBUF-1:0] rtr_reg;
  logic [15:0] irq_en_reg, irq_pend_reg, code_en_reg;
  logic [DIAG_W-1:0] diag_reg;
  logic [3:0] sel_reg, buf_sel_reg;
  tx_state_t state_reg;
  pick_t cand;
  logic [15:0] evt;
  logic [4:0] stat_code;
  logic wr, rd, buf_wr, mapped;
  logic [3:0] cur_code;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable;
  assign buf_wr = wr && (paddr == OFF_BUF_STAT) && (buf_sel_reg < 4'(NBUF));
  assign cur_code = code_reg[sel_reg];

  // only requested, idle buffers compete; recomputed every cycle
  always_comb begin
    cand = '0;
    for (int i = 0; i < NBUF; i++) begin
      if (sendable(code_reg[i]) && !code_reg[i][0]) begin // RL24 RL8
        // strict compare keeps the lower index on a tie
        if (!cand.valid || comb_pri(pri_reg[i], 4'(i)) <
            comb_pri(pri_reg[cand.idx], cand.idx)) begin // RL3 RL4
          cand.valid = 1'b1;
          cand.idx = 4'(i);
        end
      end
    end
  end

  // ***************
  // transmit scheduler
  // ***************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= TX_IDLE;
      sel_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        TX_IDLE: begin
          if (cand.valid) begin
            state_reg <= TX_SCHED; // RL10
            sel_reg <= cand.idx;
          end
        end
        TX_SCHED: begin
          if (!cur_code[0] || !sendable(cur_code)) begin
            state_reg <= TX_IDLE; // cancelled by software
          end else if (tx_evt.start) begin
            state_reg <= TX_FLIGHT;
          end else if (cand.valid && comb_pri(pri_reg[cand.idx], cand.idx) <
                       comb_pri(pri_reg[sel_reg], sel_reg)) begin
            sel_reg <= cand.idx; // RL3
          end
        end
        TX_FLIGHT: begin
          if (tx_evt.done) begin
            // no bus release between queued frames
            state_reg <= cand.valid ? TX_SCHED : TX_IDLE; // RL1
            if (cand.valid) begin
              sel_reg <= cand.idx;
            end
          end else if (tx_evt.fail) begin
            state_reg <= sendable(cur_code) ? TX_SCHED : TX_IDLE; // RL22
          end
        end
        default: state_reg <= TX_IDLE;
      endcase
    end
  end

  // ***************
  // buffer status codes; later assignments win
  // ***************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NBUF; i++) begin
        code_reg[i] <= RX_NOT_ACTIVE;
      end
    end else begin
      for (int i = 0; i < NBUF; i++) begin
        if (rx_data_hit[i] && code_reg[i] == RX_READY) begin
          code_reg[i] <= RX_FULL;
        end else if (rx_data_hit[i] && code_reg[i] == RX_FULL) begin
          code_reg[i] <= RX_OVERRUN;
        end
        if (rx_remote_hit[i] && code_reg[i] == WAIT_FOR_REMOTE) begin
          code_reg[i] <= SEND_ONCE_THEN_ANSWER; // RL9 RL13
        end
      end
      unique case (state_reg)
        TX_IDLE: begin
          if (cand.valid) begin
            code_reg[cand.idx] <= code_reg[cand.idx] | 4'h1; // RL10 RL12
          end
        end
        TX_SCHED: begin
          if (!sendable(cur_code)) begin
            code_reg[sel_reg] <= {cur_code[3:1], 1'b0};
          end else if (!tx_evt.start && cand.valid &&
                       comb_pri(pri_reg[cand.idx], cand.idx) <
                       comb_pri(pri_reg[sel_reg], sel_reg)) begin
            // displaced request stays pending
            code_reg[sel_reg] <= {cur_code[3:1], 1'b0};
            code_reg[cand.idx] <= code_reg[cand.idx] | 4'h1;
          end
        end
        TX_FLIGHT: begin
          if (tx_evt.done) begin
            code_reg[sel_reg] <= done_code(cur_code, rtr_reg[sel_reg]);
            if (cand.valid) begin
              code_reg[cand.idx] <= code_reg[cand.idx] | 4'h1; // RL1
            end
          end else if (tx_evt.fail && !sendable(cur_code)) begin
            code_reg[sel_reg] <= {cur_code[3:1], 1'b0};
          end
        end
        default: ;
      endcase
      // the busy bit is never software writable; it survives only in flight
      if (buf_wr) begin
        code_reg[buf_sel_reg] <= {pwdata[3:1], state_reg == TX_FLIGHT &&
            sel_reg == buf_sel_reg && !tx_evt.done}; // RL21 RL14 RL8
      end
    end
  end

  // priority field and rtr bit, locked while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NBUF; i++) begin
        pri_reg[i] <= 4'h0;
      end
      rtr_reg <= '0;
    end else if (buf_wr && !code_reg[buf_sel_reg][0]) begin // RL21
      pri_reg[buf_sel_reg] <= pwdata[PRI_LSB+3:PRI_LSB];
      rtr_reg[buf_sel_reg] <= pwdata[RTR_BIT];
    end
  end

  // ***************
  // interrupt events and registers
  // ***************
  always_comb begin
    evt = '0;
    for (int i = 0; i < NBUF; i++) begin
      evt[i] = (rx_data_hit[i] && (code_reg[i] == RX_READY || code_reg[i] == RX_FULL)) ||
               (rx_remote_hit[i] && code_reg[i] == WAIT_FOR_REMOTE) ||
               (state_reg == TX_FLIGHT && tx_evt.done && sel_reg == 4'(i) &&
                sendable(code_reg[i])); // RL16
    end
    evt[ERR_BIT] = bus_error; // RL17
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pend_reg <= 16'h0000;
    end else if (wr && paddr == OFF_IRQ_CLR) begin
      irq_pend_reg <= (irq_pend_reg & ~pwdata[15:0]) | evt; // RL18
    end else begin
      irq_pend_reg <= irq_pend_reg | evt;
    end
  end

  // diagnostic bits clear by writing ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag_reg <= '0;
    end else begin
      diag_reg <= (wr && paddr == OFF_ERR_DIAG ? diag_reg & ~pwdata[DIAG_W-1:0] : diag_reg) |
                  (bus_error ? error_bits : '0); // RL17
    end
  end

  // software configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_reg <= IRQ_EN_RST;
      code_en_reg <= CODE_EN_RST;
      buf_sel_reg <= 4'h0;
    end else if (wr) begin
      if (paddr == OFF_IRQ_EN) irq_en_reg <= pwdata[15:0]; // RL18
      if (paddr == OFF_CODE_EN) code_en_reg <= pwdata[15:0];
      if (paddr == OFF_BUF_SEL) buf_sel_reg <= pwdata[3:0];
    end
  end

  assign stat_code = irq_code(irq_pend_reg & irq_en_reg & code_en_reg); // RL19
  assign can_irq = |(irq_pend_reg & irq_en_reg); // RL15
  assign rx_wake = |(evt[NBUF-1:0] & rx_data_hit); // RL15
  assign tx_req = (state_reg == TX_SCHED);
  assign tx_index = sel_reg;
  assign tx_remote = rtr_reg[sel_reg];

  // ***************
  // apb read path, data captured in the setup cycle
  // ***************
  always_comb begin
    mapped = (paddr[1:0] == 2'b00) && (paddr <= OFF_BUF_STAT);
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      unique case (paddr)
        OFF_IRQ_EN: prdata <= {16'h0000, irq_en_reg};
        OFF_IRQ_PEND: prdata <= {16'h0000, irq_pend_reg};
        OFF_CODE_EN: prdata <= {16'h0000, code_en_reg};
        OFF_STAT_PEND: prdata <= {27'h0, stat_code};
        OFF_ERR_DIAG: prdata <= {{(32 - DIAG_W){1'b0}}, diag_reg};
        OFF_BUF_SEL: prdata <= {28'h0, buf_sel_reg};
        OFF_BUF_STAT: prdata <= (buf_sel_reg < 4'(NBUF)) ?
            {23'h0, rtr_reg[buf_sel_reg], pri_reg[buf_sel_reg], code_reg[buf_sel_reg]} : '0;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ***************
  // checks
  // ***************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pick_smallest_a: assert property ( // RL3
    state_reg == TX_IDLE && cand.valid |=> state_reg == TX_SCHED && sel_reg == $past(cand.idx))
    else $error("idle scheduler did not take the smallest candidate");
  sched_busy_a: assert property ( // RL10
    state_reg == TX_SCHED && $past(state_reg) == TX_IDLE |-> cur_code[0])
    else $error("scheduled buffer not busy");
  back_to_back_a: assert property ( // RL1
    state_reg == TX_FLIGHT && tx_evt.done && cand.valid |=> tx_req)
    else $error("queued frame did not follow at once");
  answer_busy_a: assert property ( // RL12
    state_reg == TX_FLIGHT && cur_code[3:1] == 3'b111 |-> cur_code == 4'hf)
    else $error("answer frame in flight does not read 1111b");
  remote_auto_a: assert property ( // RL9
    rx_remote_hit[2] && code_reg[2] == WAIT_FOR_REMOTE && !buf_wr
    |=> code_reg[2] == SEND_ONCE_THEN_ANSWER ##[1:3] state_reg != TX_IDLE)
    else $error("remote frame did not trigger an answer");
  err_irq_a: assert property ( // RL15 RL17
    bus_error && irq_en_reg[ERR_BIT] |=> can_irq && irq_pend_reg[ERR_BIT])
    else $error("bus error did not raise the interrupt");
  pend_clear_a: assert property ( // RL18
    wr && paddr == OFF_IRQ_CLR && pwdata[ERR_BIT] && !bus_error |=> !irq_pend_reg[ERR_BIT])
    else $error("error pending flag not cleared");
  err_code_a: assert property ( // RL20
    irq_pend_reg[ERR_BIT] && irq_en_reg[ERR_BIT] && code_en_reg[ERR_BIT]
    |-> stat_code == 5'h10)
    else $error("error request not coded highest");
  retry_a: assert property ( // RL22
    state_reg == TX_FLIGHT && tx_evt.fail && sendable(cur_code) && !buf_wr
    |=> state_reg == TX_SCHED && cur_code[0] && sel_reg == $past(sel_reg))
    else $error("failed frame not retried");
endmodule : can_tx_priority_and_irq_code
`default_nettype wire

// ==== sim/eng_model.sv ====
// protocol engine stand-in: starts scheduled frames and reports their outcome
// assumes the bench opens the gate and may ask for a failed frame
`timescale 1ns/100ps
`default_nettype none
module eng_model
  import can_tx_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench controls
  input wire logic go,
  input wire logic fail_next,
  // scheduler side
  input wire logic tx_req,
  output var tx_evt_t tx_evt
);
  logic busy_reg;
  logic [4:0] cnt_reg;
  // ***************
  // frame sequencer, fixed 16-cycle frames
  // ***************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      cnt_reg <= 5'h00;
      tx_evt <= '0;
    end else begin
      tx_evt <= '0;
      if (!busy_reg && go && tx_req) begin
        tx_evt.start <= 1'b1;
        busy_reg <= 1'b1;
        cnt_reg <= 5'h10;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg - 5'h01;
        // lost arbitration only when the bench asks, to exercise retry
        if (cnt_reg == 5'h01) begin
          busy_reg <= 1'b0;
          tx_evt.done <= !fail_next;
          tx_evt.fail <= fail_next;
        end
      end
    end
  end
endmodule : eng_model
`default_nettype wire

// ==== sim/test_can_tx_priority_and_irq_code.sv ====
// self-checking bench for the transmit scheduler and interrupt coder
// assumes the engine model and apb with pready tied high
`timescale 1ns/100ps
`default_nettype none
module test_can_tx_priority_and_irq_code
  import can_tx_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, bus_error;
  logic tx_req, tx_remote, can_irq, rx_wake, go, fail_next;
  logic [7:0] paddr, error_bits;
  logic [31:0] pwdata, prdata, q;
  logic e;
  logic [NBUF-1:0] rx_remote_hit, rx_data_hit;
  logic [3:0] tx_index;
  logic [3:0] starts[$];
  tx_evt_t tx_evt;
  int n_fail, compares, n_done, n_lost;
  can_tx_priority_and_irq_code dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_evt(tx_evt), .rx_remote_hit(rx_remote_hit),
    .rx_data_hit(rx_data_hit), .bus_error(bus_error), .error_bits(error_bits),
    .tx_req(tx_req), .tx_index(tx_index), .tx_remote(tx_remote), .can_irq(can_irq),
    .rx_wake(rx_wake));
  eng_model eng (.pclk(pclk), .presetn(presetn), .go(go), .fail_next(fail_next),
    .tx_req(tx_req), .tx_evt(tx_evt));
  // ***************
  // clock, engine monitor, watchdog
  // ***************
  always #2 pclk = ~pclk;
  // record which buffer each frame carried
  always @(posedge pclk) begin
    if (tx_evt.start === 1'b1) starts.push_back(tx_index);
    if (tx_evt.done === 1'b1) n_done++;
    if (tx_evt.fail === 1'b1) n_lost++;
  end
  // whole run is a few hundred cycles, so this margin only trips on a hang
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    end_of_test();
  end
  // ***************
  // tasks
  // ***************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one transfer, then an idle edge so psel is never driven twice at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  task automatic bufw(input logic [3:0] n, input logic [31:0] v);
    apb(1'b1, OFF_BUF_SEL, {28'h0, n});
    // park the buffer inactive with its fields loaded, then trigger it
    apb(1'b1, OFF_BUF_STAT, {v[31:4], TX_NOT_ACTIVE});
    apb(1'b1, OFF_BUF_STAT, v);
  endtask : bufw
  task automatic bufr(input logic [3:0] n, input logic [31:0] exp);
    apb(1'b1, OFF_BUF_SEL, {28'h0, n});
    rd(OFF_BUF_STAT, exp);
  endtask : bufr
  // sel 0 frames begun, 1 frames sent, 2 frames lost
  task automatic wait_ev(input int sel, input int n);
    int k;
    k = 0;
    while (((sel == 0) ? starts.size() : (sel == 1) ? n_done : n_lost) < n && k < 500) begin
      @(posedge pclk);
      k++;
    end
    // a missing event is a mismatch and ends the run at once
    if (((sel == 0) ? starts.size() : (sel == 1) ? n_done : n_lost) < n) begin
      n_fail++;
      $display("BAD t=%0t engine event %0d not seen", $time, sel);
      end_of_test();
    end
  endtask : wait_ev
  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // ***************
  // main sequence
  // ***************
  initial begin
    {presetn, psel, penable, pwrite, bus_error, go, fail_next} = '0;
    {paddr, error_bits, pwdata, rx_remote_hit, rx_data_hit} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_IRQ_EN, 32'h0);
    rd(OFF_CODE_EN, 32'hffff);
    rd(OFF_STAT_PEND, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, OFF_IRQ_EN, 32'hffff);
    // four queued frames, gate closed so displacement can be seen
    bufw(4'h0, 32'h0ec);
    bufw(4'he, 32'h00c);
    bufw(4'h5, 32'h02c);
    bufw(4'h3, 32'h02c);
    chk({31'h0, tx_req}, 32'h1);
    chk({28'h0, tx_index}, 32'he);
    bufr(4'he, 32'h00d);
    bufr(4'h0, 32'h0ec);
    go <= 1'b1;
    wait_ev(1, 4);
    chk({starts[0], starts[1], starts[2], starts[3]}, 32'he350);
    bufr(4'h0, 32'h0e8);
    rd(OFF_IRQ_PEND, 32'h4029);
    rd(OFF_STAT_PEND, 32'h11);
    chk({31'h0, can_irq}, 32'h1);
    apb(1'b1, OFF_IRQ_CLR, 32'h0001);
    rd(OFF_STAT_PEND, 32'h14);
    apb(1'b1, OFF_CODE_EN, 32'h4000);
    rd(OFF_STAT_PEND, 32'h1f);
    apb(1'b1, OFF_IRQ_PEND, 32'h0);
    rd(OFF_IRQ_PEND, 32'h4028);
    apb(1'b1, OFF_IRQ_CLR, 32'hffff);
    apb(1'b1, OFF_CODE_EN, 32'hffff);
    chk({31'h0, can_irq}, 32'h0);
    // remote request frame returns to receive-ready
    bufw(4'h1, 32'h10c);
    wait_ev(0, 5);
    chk({31'h0, tx_remote}, 32'h1);
    wait_ev(1, 5);
    bufr(4'h1, 32'h102);
    rd(OFF_STAT_PEND, 32'h12);
    // answer mode: send, wait, answer a remote frame
    bufw(4'h2, 32'h00e);
    wait_ev(0, 6);
    bufr(4'h2, 32'h00f);
    wait_ev(1, 6);
    bufr(4'h2, 32'h00a);
    rx_remote_hit <= 15'h0004;
    @(posedge pclk);
    rx_remote_hit <= 15'h0;
    wait_ev(0, 7);
    bufr(4'h2, 32'h00f);
    wait_ev(1, 7);
    bufr(4'h2, 32'h00a);
    // wait-for-remote alone sends nothing
    bufw(4'h4, 32'h00a);
    chk({31'h0, tx_req}, 32'h0);
    rx_remote_hit <= 15'h0010;
    @(posedge pclk);
    rx_remote_hit <= 15'h0;
    wait_ev(1, 8);
    chk({28'h0, starts[7]}, 32'h4);
    // a lost frame stays busy and is retried
    fail_next <= 1'b1;
    bufw(4'h6, 32'h00c);
    wait_ev(2, 1);
    fail_next <= 1'b0;
    bufr(4'h6, 32'h00d);
    wait_ev(1, 9);
    chk({24'h0, starts[8], starts[9]}, 32'h66);
    bufr(4'h6, 32'h008);
    // data frame into a ready buffer, then a bus error
    apb(1'b1, OFF_IRQ_CLR, 32'hffff);
    bufw(4'h7, 32'h002);
    rx_data_hit <= 15'h0080;
    #1 chk({31'h0, rx_wake}, 32'h1);
    @(posedge pclk);
    rx_data_hit <= 15'h0;
    bus_error <= 1'b1;
    error_bits <= 8'h5a;
    @(posedge pclk);
    bus_error <= 1'b0;
    @(posedge pclk);
    bufr(4'h7, 32'h004);
    rd(OFF_ERR_DIAG, 32'h5a);
    rd(OFF_IRQ_PEND, 32'h8080);
    rd(OFF_STAT_PEND, 32'h10);
    end_of_test();
  end
endmodule : test_can_tx_priority_and_irq_code
`default_nettype wire
